// ---- pkg/tco_pkg.sv ----
// constants for the timer compare output control block
package tco_pkg;
    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_OUT_CTRL   = 16'h7400; // timer_output_control
    localparam logic [15:0] ADDR_CMP_CTRL   = 16'h7411; // compare_control
    localparam logic [15:0] ADDR_SACT_CTRL  = 16'h7414; // simple_action_control
    localparam logic [15:0] ADDR_SFLAG      = 16'h7415; // simple compare flags
    localparam logic [15:0] ADDR_SCMP_BASE  = 16'h7417; // simple_compare_value 1..3
    // ----------------------------------------------------------------
    // timer_output_control fields
    // ----------------------------------------------------------------
    localparam int          DIR_LSB         = 13;   // direction status, timer1 at 13
    localparam int          CONV_LSB        = 7;    // converter start select, 2 bits each
    localparam int          TOE_BIT         = 6;    // compare output enable of the three timer outputs
    localparam int          POL_LSB         = 0;    // polarity, 2 bits each
    localparam logic [2:0]  DIR_RESET       = 3'h7;
    // ----------------------------------------------------------------
    // compare_control fields
    // ----------------------------------------------------------------
    localparam int          CEN_BIT         = 15;   // compare enable
    localparam int          SOE_BIT         = 8;    // simple compare output enable
    localparam int          SEL_TMR_BIT     = 7;    // simple timebase select
    localparam int          SCLD_LSB        = 5;    // simple compare reload condition
    localparam int          SACLD_LSB       = 3;    // simple action reload condition
    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [1:0]  CONV_NONE       = 2'h0;
    localparam logic [1:0]  CONV_UFL        = 2'h1;
    localparam logic [1:0]  CONV_PRD        = 2'h2;
    localparam logic [1:0]  CONV_CMP        = 2'h3;
    localparam logic [1:0]  POL_FLOW        = 2'h0;
    localparam logic [1:0]  POL_ALOW        = 2'h1;
    localparam logic [1:0]  POL_AHIGH       = 2'h2;
    localparam logic [1:0]  POL_FHIGH       = 2'h3;
    localparam logic [1:0]  LD_ZERO         = 2'h0;
    localparam logic [1:0]  LD_ZERO_PRD     = 2'h1;
    localparam logic [1:0]  LD_IMM          = 2'h2;
    localparam logic [15:0] REG_RESET       = 16'h0000;
    // counting modes of the timer core
    typedef enum logic [2:0] {
        MODE_STOP   = 3'h0,
        MODE_SUP    = 3'h1,
        MODE_CUP    = 3'h2,
        MODE_DIRUD  = 3'h3,
        MODE_SUPDN  = 3'h4,
        MODE_CUPDN  = 3'h5
    } tco_mode_t;
endpackage

// ---- logic/tco_timer_output.sv ----
// timer and simple compare output control with register port
`timescale 1ns/1ps
module tco_timer_output
(
    input  wire logic              ref_clk_i,          // 200 MHz clock
    input  wire logic              srst_i,             // synchronous reset, high
    input  wire logic [15:0]       addr_i,             // register address
    input  wire logic [15:0]       wdata_i,            // write data
    input  wire logic              wr_i,               // write strobe
    input  wire logic              rd_i,               // read strobe
    output logic      [15:0]       rdata_o,            // read data, cycle after rd_i
    input  wire logic              power_drive_protect_n_i, // protect, low active
    input  wire logic [2:0]        tmr_dir_up_i,       // per timer: counting up
    input  wire logic [2:0][2:0]   tmr_mode_i,         // per timer counting mode
    input  wire logic [2:0]        tmr_cmp_en_i,       // per timer compare enable
    input  wire logic [2:0]        tmr_cmp_evt_i,      // compare flag sets
    input  wire logic [2:0]        tmr_prd_evt_i,      // period flag sets
    input  wire logic [2:0]        tmr_ufl_evt_i,      // underflow flag sets
    input  wire logic [1:0][15:0]  tb_cnt_i,           // timer 1,2 counter values
    input  wire logic [1:0][15:0]  tb_prd_i,           // timer 1,2 period values
    output logic      [2:0]        tmr_pwm_o,          // timer compare output levels
    output logic      [2:0]        tmr_pwm_oe_n_o,     // low while driven
    output logic      [2:0]        smp_pwm_o,          // simple compare output levels
    output logic      [2:0]        smp_pwm_oe_n_o,     // low while driven
    output logic      [2:0]        conv_start_o        // converter start pulses
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0]       out_ctrl_q;     // writable bits of timer_output_control
    logic [2:0]        dir_q;          // direction status copy
    logic [15:0]       cmp_ctrl_q;     // compare_control
    logic [15:0]       sact_sh_q;      // simple_action_control shadow
    logic [15:0]       sact_q;         // active action bits
    logic [2:0][15:0]  scmp_sh_q;      // simple_compare_value shadows
    logic [2:0][15:0]  scmp_q;         // active simple compare values
    logic [2:0]        sflag_q;        // simple compare flags
    logic [2:0]        tact_q;         // timer output active state
    logic [2:0]        sact_st_q;      // simple output active state
    logic [15:0]       cnt_prev_q;     // last time-base count, for edge of match
    logic [15:0]       rdata_q;
    logic [15:0]       rd_d;

    // selected time base for the simple units
    logic [15:0]       tb_cnt;
    logic [15:0]       tb_prd;
    logic [2:0]        tb_mode;
    logic              tb_step;
    logic              tb_zero;
    logic              tb_pmatch;
    logic              reload_cmp;
    logic              reload_act;
    logic              sel_tmr;
    logic              cen;

    assign sel_tmr   = cmp_ctrl_q[tco_pkg::SEL_TMR_BIT];
    assign cen       = cmp_ctrl_q[tco_pkg::CEN_BIT];
    assign tb_cnt    = sel_tmr ? tb_cnt_i[1] : tb_cnt_i[0];
    assign tb_prd    = sel_tmr ? tb_prd_i[1] : tb_prd_i[0];
    assign tb_mode   = sel_tmr ? tmr_mode_i[1] : tmr_mode_i[0];
    // a held count must not match again while the prescaler stalls it
    assign tb_step   = tb_cnt != cnt_prev_q;
    assign tb_zero   = tb_step && (tb_cnt == 16'h0000);
    assign tb_pmatch = tb_step && (tb_cnt == tb_prd);

    // reload decision: disabled compare makes the shadows transparent
    function automatic logic reload_now(input logic [1:0] cond, input logic en,
                                        input logic zero, input logic pm);
        logic r;
        r = 1'b0;
        case (cond)
            tco_pkg::LD_ZERO:     r = zero;
            tco_pkg::LD_ZERO_PRD: r = zero | pm;
            tco_pkg::LD_IMM:      r = 1'b1;
            default:              r = 1'b0;
        endcase
        return r | ~en;
    endfunction

    // output level from polarity and active state
    function automatic logic pol_level(input logic [1:0] pol, input logic act);
        logic l;
        l = 1'b0;
        case (pol)
            tco_pkg::POL_FLOW:  l = 1'b0;
            tco_pkg::POL_ALOW:  l = ~act;
            tco_pkg::POL_AHIGH: l = act;
            tco_pkg::POL_FHIGH: l = 1'b1;
            default:            l = 1'b0;
        endcase
        return l;
    endfunction

    assign reload_cmp = reload_now(cmp_ctrl_q[tco_pkg::SCLD_LSB +: 2], cen,
                                   tb_zero, tb_pmatch);
    assign reload_act = reload_now(cmp_ctrl_q[tco_pkg::SACLD_LSB +: 2], cen,
                                   tb_zero, tb_pmatch);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // protect outranks a software write of the enable bits in the same cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            out_ctrl_q <= tco_pkg::REG_RESET;
            cmp_ctrl_q <= tco_pkg::REG_RESET;
            sact_sh_q  <= tco_pkg::REG_RESET;
        end
        else
        begin
            if (wr_i && addr_i == tco_pkg::ADDR_OUT_CTRL)
                out_ctrl_q <= {3'h0, wdata_i[12:0]};
            if (wr_i && addr_i == tco_pkg::ADDR_CMP_CTRL)
                cmp_ctrl_q <= wdata_i;
            if (wr_i && addr_i == tco_pkg::ADDR_SACT_CTRL)
                sact_sh_q  <= wdata_i;
            if (!power_drive_protect_n_i)
            begin
                out_ctrl_q[tco_pkg::TOE_BIT] <= 1'b0;
                cmp_ctrl_q[tco_pkg::SOE_BIT] <= 1'b0;
            end
        end
    end

    // direction status copy, all ones out of reset
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            dir_q <= tco_pkg::DIR_RESET;
        else
            dir_q <= tmr_dir_up_i;
    end

    // time-base history and action register reload
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            cnt_prev_q <= tco_pkg::REG_RESET;
            sact_q     <= tco_pkg::REG_RESET;
        end
        else
        begin
            cnt_prev_q <= tb_cnt;
            if (reload_act)
                sact_q <= sact_sh_q;
        end
    end

    // ----------------------------------------------------------------
    // per-timer compare outputs and converter start
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_tmr
            logic [1:0] conv_sel;
            logic [1:0] pol;
            logic       updn;
            logic       trig;
            assign conv_sel = out_ctrl_q[tco_pkg::CONV_LSB + 2*i +: 2];
            assign pol      = out_ctrl_q[tco_pkg::POL_LSB + 2*i +: 2];
            assign updn     = tmr_mode_i[i] == tco_pkg::MODE_SUPDN ||
                              tmr_mode_i[i] == tco_pkg::MODE_CUPDN;
            // selected flag-setting event, same edge the core sets its flag
            always_comb
            begin
                trig = 1'b0;
                case (conv_sel)
                    tco_pkg::CONV_UFL: trig = tmr_ufl_evt_i[i];
                    tco_pkg::CONV_PRD: trig = tmr_prd_evt_i[i];
                    tco_pkg::CONV_CMP: trig = tmr_cmp_evt_i[i];
                    default:           trig = 1'b0;
                endcase
            end

            // active state; each timer runs independently
            always_ff @(posedge ref_clk_i)
            begin
                if (srst_i)
                    tact_q[i] <= 1'b0;
                else if (tmr_mode_i[i] == tco_pkg::MODE_DIRUD || !tmr_cmp_en_i[i])
                    tact_q[i] <= tact_q[i];
                else if (updn)
                begin
                    if (tmr_cmp_evt_i[i])
                        tact_q[i] <= ~tact_q[i];
                    else if (tmr_ufl_evt_i[i])
                        tact_q[i] <= 1'b0;
                end
                else if (tmr_cmp_evt_i[i])
                    tact_q[i] <= 1'b1;
                else if (tmr_prd_evt_i[i])
                    tact_q[i] <= 1'b0;
            end

            // output pins straight from flops
            always_ff @(posedge ref_clk_i)
            begin
                if (srst_i)
                begin
                    tmr_pwm_o[i]      <= 1'b0;
                    tmr_pwm_oe_n_o[i] <= 1'b1;
                    conv_start_o[i]   <= 1'b0;
                end
                else
                begin
                    tmr_pwm_o[i]      <= pol_level(pol, tact_q[i]);
                    tmr_pwm_oe_n_o[i] <= ~out_ctrl_q[tco_pkg::TOE_BIT];
                    conv_start_o[i]   <= trig;
                end
            end

            a_conv_none_quiet : assert property (@(posedge ref_clk_i) disable iff (srst_i)
                (conv_sel == tco_pkg::CONV_NONE) |=> !conv_start_o[i])
                else $error("converter start without selected event");
            a_conv_pulse_cmp : assert property (@(posedge ref_clk_i) disable iff (srst_i)
                (conv_sel == tco_pkg::CONV_CMP && tmr_cmp_evt_i[i]) |=> conv_start_o[i])
                else $error("compare event gave no converter start");
            a_forced_high_level : assert property (@(posedge ref_clk_i) disable iff (srst_i)
                (pol == tco_pkg::POL_FHIGH) [*2] |-> tmr_pwm_o[i])
                else $error("forced high output not high");
            a_up_match_active : assert property (@(posedge ref_clk_i) disable iff (srst_i)
                (tmr_mode_i[i] == tco_pkg::MODE_CUP && tmr_cmp_en_i[i] && tmr_cmp_evt_i[i]
                 && pol == tco_pkg::POL_AHIGH && $stable(pol)) |=> ##1 tmr_pwm_o[i])
                else $error("compare match did not set output active");
            a_dir_mode_hold : assert property (@(posedge ref_clk_i) disable iff (srst_i)
                (tmr_mode_i[i] == tco_pkg::MODE_DIRUD) |=> $stable(tact_q[i]))
                else $error("output moved in directional mode");
        end
    endgenerate

    // ----------------------------------------------------------------
    // simple compare units
    // ----------------------------------------------------------------
    generate
        for (i = 0; i < 3; i++)
        begin : g_smp
            logic match;
            logic updn;
            logic set_flag;
            logic clr_flag;
            assign match    = cen && tb_step && (tb_cnt == scmp_q[i]);
            assign updn     = tb_mode == tco_pkg::MODE_SUPDN || tb_mode == tco_pkg::MODE_CUPDN;
            assign set_flag = match;
            assign clr_flag = wr_i && addr_i == tco_pkg::ADDR_SFLAG && wdata_i[i];

            // shadow and active compare value
            always_ff @(posedge ref_clk_i)
            begin
                if (srst_i)
                begin
                    scmp_sh_q[i] <= tco_pkg::REG_RESET;
                    scmp_q[i]    <= tco_pkg::REG_RESET;
                end
                else
                begin
                    if (wr_i && addr_i == tco_pkg::ADDR_SCMP_BASE + 16'(i))
                        scmp_sh_q[i] <= wdata_i;
                    if (reload_cmp)
                        scmp_q[i] <= scmp_sh_q[i];
                end
            end

            // flag: a match in the clearing cycle still sets it
            always_ff @(posedge ref_clk_i)
            begin
                if (srst_i)
                    sflag_q[i] <= 1'b0;
                else if (set_flag)
                    sflag_q[i] <= 1'b1;
                else if (clr_flag)
                    sflag_q[i] <= 1'b0;
            end

            // active state, same sequence as the timers
            always_ff @(posedge ref_clk_i)
            begin
                if (srst_i)
                    sact_st_q[i] <= 1'b0;
                else if (tb_mode == tco_pkg::MODE_DIRUD)
                    sact_st_q[i] <= sact_st_q[i];
                else if (updn)
                begin
                    if (match)
                        sact_st_q[i] <= ~sact_st_q[i];
                    else if (cen && tb_zero)
                        sact_st_q[i] <= 1'b0;
                end
                else if (match)
                    sact_st_q[i] <= 1'b1;
                else if (cen && tb_pmatch)
                    sact_st_q[i] <= 1'b0;
            end

            // pins; action bits give the polarity per unit
            always_ff @(posedge ref_clk_i)
            begin
                if (srst_i)
                begin
                    smp_pwm_o[i]      <= 1'b0;
                    smp_pwm_oe_n_o[i] <= 1'b1;
                end
                else
                begin
                    smp_pwm_o[i]      <= pol_level(sact_q[2*i +: 2], sact_st_q[i]);
                    smp_pwm_oe_n_o[i] <= ~cmp_ctrl_q[tco_pkg::SOE_BIT];
                end
            end

            a_flag_set_wins : assert property (@(posedge ref_clk_i) disable iff (srst_i)
                (set_flag && clr_flag) |=> sflag_q[i])
                else $error("simple flag lost on clear collision");
            a_imm_reload : assert property (@(posedge ref_clk_i) disable iff (srst_i)
                (cen && cmp_ctrl_q[tco_pkg::SCLD_LSB +: 2] == tco_pkg::LD_IMM)
                |=> scmp_q[i] == $past(scmp_sh_q[i]))
                else $error("immediate reload missed");
        end
    endgenerate

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // unmapped addresses read zero
    always_comb
    begin
        rd_d = tco_pkg::REG_RESET;
        case (addr_i)
            tco_pkg::ADDR_OUT_CTRL:      rd_d = {dir_q[2], dir_q[1], dir_q[0],
                                                 out_ctrl_q[12:0]};
            tco_pkg::ADDR_CMP_CTRL:      rd_d = cmp_ctrl_q;
            tco_pkg::ADDR_SACT_CTRL:     rd_d = sact_sh_q;
            tco_pkg::ADDR_SFLAG:         rd_d = {13'h0000, sflag_q};
            tco_pkg::ADDR_SCMP_BASE:     rd_d = scmp_sh_q[0];
            tco_pkg::ADDR_SCMP_BASE + 16'h0001: rd_d = scmp_sh_q[1];
            tco_pkg::ADDR_SCMP_BASE + 16'h0002: rd_d = scmp_sh_q[2];
            default:                     rd_d = tco_pkg::REG_RESET;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            rdata_q <= tco_pkg::REG_RESET;
        else
            rdata_q <= rd_i ? rd_d : tco_pkg::REG_RESET;
    end
    assign rdata_o = rdata_q;

    a_protect_clears_oe : assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !power_drive_protect_n_i |=> ##1 (tmr_pwm_oe_n_o == 3'h7))
        else $error("protect did not tri-state timer outputs");
    a_reset_dir_ones : assert property (@(posedge ref_clk_i)
        srst_i |=> (dir_q == tco_pkg::DIR_RESET && tmr_pwm_oe_n_o == 3'h7))
        else $error("reset state wrong");
endmodule

// ---- sim/tco_power_stage.sv ----
// model of the power stage pins
`timescale 1ns/1ps
module tco_power_stage
(
    input  wire logic       ref_clk_i,    // clock
    input  wire logic [2:0] pwm_i,        // driven levels
    input  wire logic [2:0] pwm_oe_n_i,   // low while driven
    output logic      [2:0] pin_o         // resolved pin levels
);
    logic [2:0] last_q; // last level each pin was driven to
    // a released pin shows the inverse of its last driven level, so a stale drive never looks right
    always_ff @(posedge ref_clk_i)
    begin
        last_q <= (pwm_oe_n_i & last_q) | (~pwm_oe_n_i & pwm_i);
    end
    // resolve each tri-state pin
    always_comb
    begin
        pin_o = (pwm_oe_n_i & ~last_q) | (~pwm_oe_n_i & pwm_i);
    end
endmodule

// ---- sim/tb_timer_compare_output_control.sv ----
// register and event sequence bench for the timer output control block
`timescale 1ns/1ps
module tb_timer_compare_output_control;
    logic ref_clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, prot_n = 1'b1;
    logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, rdata_o, d;
    logic [2:0] dir = 3'h7, cen = 3'h7, ce = 3'h0, pe = 3'h0, ue = 3'h0, pwm, oe_n, sp, so, cs, pin;
    logic [2:0][2:0] mode = {3{3'h2}};
    logic [15:0] cnt = 16'h0000; // timer 1 count seen by the simple units
    // period for ten input clocks in continuous-up, less one
    localparam logic [15:0] PRD = 16'h000A - 16'h0001;
    int failures = 0, samples_checked = 0, cycles = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    tco_timer_output i_tco_timer_output (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .power_drive_protect_n_i(prot_n), .tmr_dir_up_i(dir), .tmr_mode_i(mode),
        .tmr_cmp_en_i(cen), .tmr_cmp_evt_i(ce), .tmr_prd_evt_i(pe), .tmr_ufl_evt_i(ue),
        .tb_cnt_i({16'h0000, cnt}), .tb_prd_i({PRD, PRD}), .tmr_pwm_o(pwm),
        .tmr_pwm_oe_n_o(oe_n), .smp_pwm_o(sp), .smp_pwm_oe_n_o(so), .conv_start_o(cs));
    tco_power_stage i_tco_power_stage (.ref_clk_i(ref_clk_i), .pwm_i(pwm),
        .pwm_oe_n_i(oe_n), .pin_o(pin));
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge ref_clk_i);
        addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // one-cycle event pulses, then converter start and pin level a cycle apart
    task automatic ev(input logic [2:0] c, p, u, ecs, epin);
        @(posedge ref_clk_i);
        ce <= c; pe <= p; ue <= u;
        @(posedge ref_clk_i);
        ce <= 3'h0; pe <= 3'h0; ue <= 3'h0;
        #1 chk("conv", {13'h0, cs}, {13'h0, ecs});
        @(posedge ref_clk_i);
        #1 chk("pin", {13'h0, pin}, {13'h0, epin});
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard, far above the roughly 135 cycles the tests need
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            stop_test();
        end
    end
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        #1 chk("oe reset", {13'h0, oe_n}, 16'h0007);
        rd(tco_pkg::ADDR_OUT_CTRL); chk("ctrl reset", d, 16'hE000);
        rd(16'h7401); chk("unmapped", d, 16'h0000);
        $display("test reset done");
        @(posedge ref_clk_i);
        dir <= 3'h5;
        wr(tco_pkg::ADDR_OUT_CTRL, 16'h1FF2);
        rd(tco_pkg::ADDR_OUT_CTRL); chk("ctrl rd", d, 16'hBFF2);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("oe on", {13'h0, oe_n}, 16'h0000);
        chk("idle pin", {13'h0, pin}, 16'h0004);
        ev(3'h7, 3'h0, 3'h0, 3'h7, 3'h5);
        ev(3'h0, 3'h7, 3'h0, 3'h0, 3'h4);
        $display("test output done");
        for (int k = 0; k < 4; k++)
        begin
            wr(tco_pkg::ADDR_OUT_CTRL, 16'h0072 | ({10'h0, {3{k[1:0]}}} << 7));
            ev(3'h0, 3'h0, 3'h7, (k == 1) ? 3'h7 : 3'h0, 3'h4);
            ev(3'h0, 3'h7, 3'h0, (k == 2) ? 3'h7 : 3'h0, 3'h4);
            ev(3'h7, 3'h0, 3'h0, (k == 3) ? 3'h7 : 3'h0, 3'h5);
            ev(3'h0, 3'h7, 3'h0, (k == 2) ? 3'h7 : 3'h0, 3'h4);
        end
        $display("test converter done");
        @(posedge ref_clk_i);
        mode[0] <= 3'h3;
        ev(3'h1, 3'h0, 3'h0, 3'h1, 3'h4);
        // up/down: matches toggle, underflow clears, disabled compare holds
        @(posedge ref_clk_i);
        mode[0] <= 3'h5;
        ev(3'h1, 3'h0, 3'h0, 3'h1, 3'h5);
        ev(3'h0, 3'h0, 3'h1, 3'h0, 3'h4);
        ev(3'h1, 3'h0, 3'h0, 3'h1, 3'h5);
        ev(3'h1, 3'h0, 3'h0, 3'h1, 3'h4);
        @(posedge ref_clk_i);
        cen <= 3'h6;
        ev(3'h1, 3'h0, 3'h0, 3'h1, 3'h4);
        $display("test updown done");
        // simple units on timer 1, unit 0 active high, immediate reloads
        @(posedge ref_clk_i);
        mode[0] <= 3'h2;
        wr(tco_pkg::ADDR_SCMP_BASE, 16'h0004);
        wr(tco_pkg::ADDR_SCMP_BASE + 16'h0001, 16'h0007);
        wr(tco_pkg::ADDR_SACT_CTRL, 16'h0002);
        wr(tco_pkg::ADDR_CMP_CTRL, 16'h8150);
        rd(tco_pkg::ADDR_SCMP_BASE); chk("scmp rd", d, 16'h0004);
        for (int n = 1; n <= 5; n++) @(posedge ref_clk_i) cnt <= 16'(n);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("simple on", {10'h0, so, sp}, 16'h0001);
        rd(tco_pkg::ADDR_SFLAG); chk("flag", d, 16'h0001);
        wr(tco_pkg::ADDR_SFLAG, 16'h0001);
        rd(tco_pkg::ADDR_SFLAG); chk("flag clr", d, 16'h0000);
        // the clear of unit 1 lands on its match at count 7, so the set must win
        for (int n = 6; n <= PRD; n++)
        begin
            @(posedge ref_clk_i);
            cnt <= 16'(n); addr_i <= tco_pkg::ADDR_SFLAG;
            wdata_i <= 16'h0002; wr_i <= (n == 7);
        end
        repeat (2) @(posedge ref_clk_i);
        #1 chk("simple off", {10'h0, so, sp}, 16'h0000);
        rd(tco_pkg::ADDR_SFLAG); chk("flag win", d, 16'h0002);
        $display("test simple done");
        @(posedge ref_clk_i);
        prot_n <= 1'b0;
        @(posedge ref_clk_i);
        prot_n <= 1'b1;
        rd(tco_pkg::ADDR_OUT_CTRL); chk("protect", d, 16'hBFB2);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("oe off", {10'h0, so, oe_n}, 16'h003F);
        chk("pin off", {13'h0, pin}, 16'h0003);
        $display("test protect done");
        stop_test();
    end
endmodule
